//--- pkg/wdlm_pkg.sv
// package: constants and types for the watchdog limit #2 and mux decode block
//
// Function
// - pointer 10 selects section three access
// - enabled watchdog compares limit one, then two
// - bit 8 is limit two sign
// - bit 9 picks above or below trip
// - bits 10-15 have no effect
// - eight-channel decode; negative code 000 is ground
// - four-channel decode; codes 1XX leave output open
// - diagnostic: 000 none, 001 references, else inputs
// - diagnostic decode only while config bit 11 set
// - limit two pass sets limit_two_status bit n
package wdlm_pkg;

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  localparam int WDLM_NUM_INSTR = 8;
  localparam logic [1:0] WDLM_PTR_SECTION_THREE = 2'h2;
  localparam int WDLM_CFG_PTR_LSB = 8;
  localparam int WDLM_CFG_DIAG_BIT = 11;
  localparam int WDLM_S1_WDOG_EN_BIT = 11;
  localparam int WDLM_S1_POS_LSB = 2;
  localparam int WDLM_S1_NEG_LSB = 5;
  localparam int WDLM_S3_MAG_LSB = 0;
  localparam int WDLM_S3_SIGN_BIT = 8;
  localparam int WDLM_S3_DIR_BIT = 9;
  localparam logic [15:0] WDLM_S3_USED_MASK = 16'h03FF;
  localparam logic [15:0] WDLM_S3_RESET = 16'h0000;
  localparam int WDLM_LIM2_STATUS_LSB = 8;
  localparam logic [2:0] WDLM_CODE_ZERO = 3'h0;
  localparam logic [2:0] WDLM_CODE_ONE = 3'h1;

  // ----------------------------------------------------------------
  // mux connection encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDLM_CONN_NONE = 2'h0,
    WDLM_CONN_INPUT = 2'h1,
    WDLM_CONN_GROUND = 2'h2,
    WDLM_CONN_REF = 2'h3
  } wdlm_conn_e;

  typedef struct packed {
    wdlm_conn_e kind;
    logic [2:0] channel;
  } wdlm_mux_sel_s;

  typedef struct packed {
    logic valid;
    logic [2:0] instr;
    logic [8:0] value;
  } wdlm_sample_s;

  typedef enum logic [2:0] {
    WDLM_ST_IDLE = 3'b001,
    WDLM_ST_LIMIT_ONE = 3'b010,
    WDLM_ST_LIMIT_TWO = 3'b100
  } wdlm_state_e;

endpackage

//--- rtl/wdlm_section_ram.sv
// eight-word memory holding instruction section three
`timescale 1ns/100ps
`default_nettype none
module wdlm_section_ram
  import wdlm_pkg::*;
(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [WDLM_NUM_INSTR];
  logic [15:0] rd_data_next;

  always_comb begin
    rd_data_next = mem[rd_addr];
  end

  // no reset on the array; software programs every word before use
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= rd_data_next;
  end
endmodule
`default_nettype wire

//--- rtl/wdlm_decode.sv
// section three watchdog limit compare and channel select decode
`timescale 1ns/100ps
`default_nettype none
module wdlm_decode
  import wdlm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] config_word,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] section_one_word,
  input wire logic [8:0] limit_one_value,
  input wire logic limit_one_dir,
  input wire wdlm_sample_s sample,
  input wire logic variant_four,
  input wire logic [2:0] exec_instr,
  output wdlm_mux_sel_s mux_positive_output,
  output wdlm_mux_sel_s mux_negative_output,
  output logic limit_one_event,
  output logic limit_two_event,
  output logic [7:0] limit_two_status,
  input wire logic status_read
);

  // one compare at a time: a sample that arrives while the two steps
  // are running is dropped, so the sequencer must space them out

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic wdlm_mux_sel_s decode_sel(input logic [2:0] code, input logic neg,
                                               input logic four, input logic diag);
    wdlm_mux_sel_s r;
    r.channel = code;
    r.kind = WDLM_CONN_INPUT;
    if (diag) begin
      if (code == WDLM_CODE_ZERO) begin
        r.kind = WDLM_CONN_NONE;
      end else if (code == WDLM_CODE_ONE) begin
        r.kind = WDLM_CONN_REF;
      end
    end else if (four && code[2]) begin
      r.kind = WDLM_CONN_NONE;
    end else if (neg && code == WDLM_CODE_ZERO) begin
      r.kind = WDLM_CONN_GROUND;
    end
    return r;
  endfunction

  // signed nine-bit ordering: sign bit then eight magnitude bits
  function automatic logic passed(input logic [8:0] smp, input logic [8:0] lim,
                                  input logic above);
    logic gt;
    logic lt;
    gt = $signed(smp) > $signed(lim);
    lt = $signed(smp) < $signed(lim);
    return above ? gt : lt;
  endfunction

  // ----------------------------------------------------------------
  // register access to section three
  // ----------------------------------------------------------------
  logic sec3_sel;
  logic ram_wr;
  logic [15:0] ram_wdata;
  logic [15:0] ram_rdata;
  logic [2:0] ram_rd_addr;
  logic [15:0] lim_word;

  assign sec3_sel = config_word[WDLM_CFG_PTR_LSB +: 2] == WDLM_PTR_SECTION_THREE;
  // any other pointer value addresses another section, so the write is dropped here
  assign ram_wr = reg_wr && sec3_sel;
  // unused bits are stored but never read by the compare
  assign ram_wdata = reg_wdata;

  // ----------------------------------------------------------------
  // compare sequencer
  // ----------------------------------------------------------------
  wdlm_state_e state_reg, state_next;
  logic [8:0] smp_reg, smp_next;
  logic [2:0] instr_reg, instr_next;
  logic ev1_next, ev2_next;
  logic [7:0] status_reg, status_next;
  logic [15:0] rdata_next;

  // the one read port is shared: the compare owns it while busy
  // limitation: a read issued during a compare returns the compare word,
  // so software reads the section only while the watchdog is idle
  assign ram_rd_addr = (state_reg == WDLM_ST_IDLE) ? reg_addr : instr_reg;
  assign lim_word = ram_rdata & WDLM_S3_USED_MASK;

  // ----------------------------------------------------------------
  // limit two word fields
  // ----------------------------------------------------------------
  logic [8:0] lim_two_value;
  logic lim_two_above;
  logic lim_two_trip;
  logic [7:0] status_set;

  // sign sits above the eight magnitude bits, so the pair reads as one signed word
  assign lim_two_value = {lim_word[WDLM_S3_SIGN_BIT], lim_word[WDLM_S3_MAG_LSB +: 8]};
  assign lim_two_above = lim_word[WDLM_S3_DIR_BIT];
  // the word is only valid in the second step, so the trip is gated by state
  assign lim_two_trip = (state_reg == WDLM_ST_LIMIT_TWO)
                        && passed(smp_reg, lim_two_value, lim_two_above);

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // one set term per instruction; the clear is applied before the set
  // so that a trip landing in the clearing cycle is not lost
  generate
    for (genvar gi = 0; gi < WDLM_NUM_INSTR; gi++) begin : g_flag
      assign status_set[gi] = lim_two_trip && (instr_reg == 3'(gi));
    end
  endgenerate

  wdlm_section_ram u_ram (
    .clock(clock),
    .wr_en(ram_wr),
    .wr_addr(reg_addr),
    .wr_data(ram_wdata),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_rdata)
  );

  always_comb begin
    state_next = state_reg;
    smp_next = smp_reg;
    instr_next = instr_reg;
    ev1_next = 1'b0;
    ev2_next = 1'b0;
    status_next = status_reg;
    rdata_next = sec3_sel ? ram_rdata : 16'h0000;
    if (status_read) begin
      status_next = 8'h00;
    end
    status_next = status_next | status_set;
    case (state_reg)
      WDLM_ST_IDLE: begin
        if (sample.valid && section_one_word[WDLM_S1_WDOG_EN_BIT]) begin
          smp_next = sample.value;
          instr_next = sample.instr;
          state_next = WDLM_ST_LIMIT_ONE;
        end
      end
      WDLM_ST_LIMIT_ONE: begin
        ev1_next = passed(smp_reg, limit_one_value, limit_one_dir);
        state_next = WDLM_ST_LIMIT_TWO;
      end
      WDLM_ST_LIMIT_TWO: begin
        ev2_next = lim_two_trip;
        state_next = WDLM_ST_IDLE;
      end
      default: state_next = WDLM_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= WDLM_ST_IDLE;
      smp_reg <= 9'h000;
      instr_reg <= 3'h0;
      limit_one_event <= 1'b0;
      limit_two_event <= 1'b0;
      status_reg <= 8'h00;
      reg_rdata <= 16'h0000;
    end else begin
      state_reg <= state_next;
      smp_reg <= smp_next;
      instr_reg <= instr_next;
      limit_one_event <= ev1_next;
      limit_two_event <= ev2_next;
      status_reg <= status_next;
      reg_rdata <= rdata_next;
    end
  end

  assign limit_two_status = status_reg;

  // ----------------------------------------------------------------
  // channel select decode
  // ----------------------------------------------------------------
  logic diag_on;
  wdlm_mux_sel_s pos_next, neg_next;
  // the four-channel part has no diagnostic routing, so the
  // diagnostic bit is ignored there rather than half-applied
  assign diag_on = config_word[WDLM_CFG_DIAG_BIT] && !variant_four;

  always_comb begin
    pos_next = decode_sel(section_one_word[WDLM_S1_POS_LSB +: 3], 1'b0, variant_four,
                          diag_on);
    neg_next = decode_sel(section_one_word[WDLM_S1_NEG_LSB +: 3], 1'b1, variant_four,
                          diag_on);
  end

  // registered so the switch controls never see decode glitches
  always_ff @(posedge clock) begin
    if (rst) begin
      mux_positive_output <= '{kind: WDLM_CONN_NONE, channel: 3'h0};
      mux_negative_output <= '{kind: WDLM_CONN_NONE, channel: 3'h0};
    end else begin
      mux_positive_output <= pos_next;
      mux_negative_output <= neg_next;
    end
  end

  // ----------------------------------------------------------------
  // unused inputs
  // ----------------------------------------------------------------
  // the sample carries its own instruction number, so the executing
  // index is not needed by this block
  logic unused_exec;
  assign unused_exec = ^exec_instr;
endmodule
`default_nettype wire

//--- testbench/wdlm_decode_sva.sv
// checker for the limit two compare and mux decode block
`timescale 1ns/100ps
`default_nettype none
module wdlm_decode_chk
  import wdlm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] config_word,
  input wire logic [15:0] section_one_word,
  input wire wdlm_sample_s sample,
  input wire logic variant_four,
  input wire logic status_read,
  input wire logic [15:0] reg_rdata,
  input wire wdlm_mux_sel_s mux_positive_output,
  input wire wdlm_mux_sel_s mux_negative_output,
  input wire logic limit_two_event,
  input wire logic [7:0] limit_two_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  logic [2:0] pos_code;
  assign take = sample.valid && section_one_word[11];
  assign pos_code = section_one_word[4:2];
  sequence s_diag; config_word[11] && !variant_four; endsequence
  sequence s_norm; !config_word[11] && !variant_four; endsequence
  // idle long enough that no compare word is on the read path
  sequence s_off; (config_word[9:8] != 2'h2 && !sample.valid)[*4]; endsequence
  property p_ptr; s_off |=> reg_rdata == 16'h0000; endproperty
  property p_ev2; limit_two_event |-> $past(take, 3); endproperty
  property p_stat; limit_two_event |-> limit_two_status != 8'h00; endproperty
  property p_clr; status_read |=> limit_two_event || limit_two_status == 8'h00; endproperty
  property p_dnone;
    s_diag ##0 pos_code == 3'h0 |=> mux_positive_output.kind == WDLM_CONN_NONE;
  endproperty
  property p_dref;
    s_diag ##0 section_one_word[7:5] == 3'h1 |=> mux_negative_output.kind == WDLM_CONN_REF;
  endproperty
  property p_norm;
    s_norm |=> mux_positive_output.kind == WDLM_CONN_INPUT
      && mux_positive_output.channel == $past(pos_code);
  endproperty
  property p_gnd;
    s_norm ##0 section_one_word[7:5] == 3'h0 |=> mux_negative_output.kind == WDLM_CONN_GROUND;
  endproperty
  property p_four;
    variant_four && section_one_word[7] |=> mux_negative_output.kind == WDLM_CONN_NONE;
  endproperty
  a_ptr: assert property (p_ptr) else $error("read data not zero");
  a_ev2: assert property (p_ev2) else $error("limit two event without sample");
  a_stat: assert property (p_stat) else $error("event without status bit");
  a_clr: assert property (p_clr) else $error("status not cleared");
  a_dnone: assert property (p_dnone) else $error("diagnostic code 0 connected");
  a_dref: assert property (p_dref) else $error("diagnostic code 1 not reference");
  a_norm: assert property (p_norm) else $error("normal positive select wrong");
  a_gnd: assert property (p_gnd) else $error("negative code 0 not ground");
  a_four: assert property (p_four) else $error("four channel high code connected");
endmodule
bind wdlm_decode wdlm_decode_chk u_chk (.*);
`default_nettype wire

//--- testbench/watchdog_limit_and_mux_decode_test.sv
// self-checking bench for the limit two compare and mux decode block
`timescale 1ns/100ps
`default_nettype none
module watchdog_limit_and_mux_decode_test
  import wdlm_pkg::*;
;
  logic clock = 0, rst = 1, reg_wr = 0, variant_four = 0, status_read = 0;
  logic [15:0] config_word = 16'h0200, section_one_word = 16'h0800, reg_wdata = 16'h0000;
  logic [2:0] reg_addr = 3'h0;
  wdlm_sample_s sample = '0;
  logic [15:0] reg_rdata;
  wdlm_mux_sel_s mux_positive_output, mux_negative_output;
  logic limit_one_event, limit_two_event;
  logic [7:0] limit_two_status, est = 8'h00;
  logic [8:0] limit_one_value = 9'h000;
  logic limit_one_dir = 0;
  int n_fail = 0, samples_checked = 0;
  // limit one word lives in section two; driven here to watch its event
  wdlm_decode uut (.*, .exec_instr(3'h0));
  always #12.5 clock = ~clock;
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    reg_addr = a;
    cyc(3);
    chk(reg_rdata, e);
  endtask
  task smp(input logic [2:0] i, input logic [8:0] v, input logic e1, input logic e);
    sample = '{1'b1, i, v};
    cyc(1);
    sample.valid = 0;
    cyc(1);
    chk(16'(limit_one_event), 16'(e1));
    cyc(1);
    chk(16'(limit_two_event), 16'(e));
    if (e) est[i] = 1;
  endtask
  task mchk(input wdlm_mux_sel_s s, input logic [2:0] c, input logic n, input int m);
    wdlm_conn_e k;
    k = WDLM_CONN_INPUT;
    if ((m == 2 && c[2]) || (m == 1 && c == 3'h0)) k = WDLM_CONN_NONE;
    else if (m == 1 && c == 3'h1) k = WDLM_CONN_REF;
    else if (n && c == 3'h0) k = WDLM_CONN_GROUND;
    chk(16'(s.kind), 16'(k));
    if (k == WDLM_CONN_INPUT) chk(16'(s.channel), 16'(c));
  endtask
  initial begin
    cyc(4);
    rst = 0;
    chk(16'(limit_two_status), 16'h0000);
    chk(16'(mux_positive_output.kind), 16'h0000);
    wr(3'h3, 16'hFFFB);
    config_word = 16'h0100;
    wr(3'h3, 16'h1234);
    rd(3'h3, 16'h0000);
    config_word = 16'h0200;
    rd(3'h3, 16'hFFFB);
    wr(3'h5, 16'h0010);
    smp(3'h3, 9'h000, 0, 1);
    smp(3'h3, 9'h1FA, 1, 0);
    smp(3'h3, 9'h1FB, 1, 0);
    limit_one_dir = 1;
    limit_one_value = 9'h0EF;
    smp(3'h5, 9'h0F0, 1, 0);
    smp(3'h5, 9'h1F0, 0, 1);
    section_one_word = 16'h0000;
    smp(3'h6, 9'h1F0, 0, 0);
    chk(16'(limit_two_status), 16'(est));
    status_read = 1;
    cyc(1);
    status_read = 0;
    cyc(1);
    chk(16'(limit_two_status), 16'h0000);
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 8; c++) begin
        variant_four = (m == 2);
        config_word = {4'h0, m == 1, 3'h2, 8'h00};
        section_one_word = {8'h00, 3'(c), 3'(c), 2'h0};
        cyc(1);
        mchk(mux_positive_output, 3'(c), 0, m);
        mchk(mux_negative_output, 3'(c), 1, m);
      end
    end
    summarize;
  end
  initial begin
    #20000;
    n_fail++;
    summarize;
  end
endmodule
`default_nettype wire
